// ==== verilog/gpp_pkg.sv ====
// Package for the shared-pin GPIO port block
package gpp_pkg;
	localparam int unsigned PORT_W      = 8;
	localparam int unsigned NUM_PORTS   = 4;
	localparam int unsigned ADDR_W      = 2;
	localparam logic [1:0]  SEL_PORT_A  = 2'h0;
	localparam logic [1:0]  SEL_PORT_B  = 2'h1;
	localparam logic [1:0]  SEL_PORT_C  = 2'h2;
	localparam logic [1:0]  SEL_PORT_D  = 2'h3;
	localparam logic [7:0]  DATA_RST    = 8'hFF;
	localparam logic [7:0]  DIR_RST     = 8'hFF;
	localparam int unsigned BIT_IRQ     = 5;
	localparam int unsigned BIT_TMR     = 4;
	localparam int unsigned BIT_FDIV    = 3;
	localparam int unsigned BIT_PWM0    = 0;
	localparam int unsigned BIT_PWM1    = 1;
	// Core access request: one write or read per cycle
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic       dir_sel;
		logic [1:0] port;
		logic [7:0] wdata;
		logic [7:0] bit_mask;
	} gpp_req_t;
	// Static build options
	typedef struct packed {
		logic [31:0] pull_en;
		logic [7:0]  wake_en;
		logic        fdiv_en;
		logic        pwm0_en;
		logic        pwm1_en;
	} gpp_cfg_t;
	// Core power mode
	typedef enum logic [1:0] {
		PM_RUN  = 2'b00,
		PM_HALT = 2'b01
	} gpp_pm_t;
endpackage : gpp_pkg

// ==== verilog/gpp_port.sv ====
// One 8-bit port: data latch, direction register and pin driver
`timescale 1ns/1ps
module gpp_port
	import gpp_pkg::*;
#(
	parameter int unsigned W = 8
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         wr_data,
	input  wire logic         wr_dir,
	input  wire logic [W-1:0] wdata,
	input  wire logic [W-1:0] bit_mask,
	input  wire logic [W-1:0] alt_en,
	input  wire logic [W-1:0] alt_val,
	input  wire logic [W-1:0] pin_sync,
	output logic      [W-1:0] rd_val,
	output logic      [W-1:0] pad_out,
	output logic      [W-1:0] pad_oe,
	output logic      [W-1:0] dir_q
);
	logic [W-1:0] data_ff;
	logic [W-1:0] dir_ff;
	logic [W-1:0] nxt_data;
	logic [W-1:0] nxt_dir;
	logic [W-1:0] drv_val;

	assign nxt_data = (data_ff & ~bit_mask) | (wdata & bit_mask);
	assign nxt_dir  = (dir_ff & ~bit_mask) | (wdata & bit_mask);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			data_ff <= W'(DATA_RST);
			dir_ff  <= W'(DIR_RST);
		end else begin
			if (wr_data) data_ff <= nxt_data;
			if (wr_dir) dir_ff <= nxt_dir;
		end
	end

	// output pins read back the latch
	assign rd_val = (dir_ff & pin_sync) | (~dir_ff & data_ff);
	// alternate function drives only as output
	assign drv_val = (alt_en & alt_val) | (~alt_en & data_ff);
	assign pad_out = drv_val;
	assign pad_oe  = ~dir_ff;
	assign dir_q   = dir_ff;
endmodule : gpp_port

// ==== verilog/gpp_top.sv ====
// Four shared-pin GPIO ports with wake-up and alternate functions
`timescale 1ns/1ps
// Overview of operation
// - Direction bit one makes the pin input, zero a driven output.
// - Four 8-bit ports A to D, each with data and direction register.
// - Inputs are not latched; the pin level is sampled on the read.
// - Written output data is latched and drives until rewritten.
// - Reading an output pin returns the output latch value.
// - Individual bits set or cleared; direction changeable anytime.
// - Input pins get per-pin pull-high chosen by a fixed option.
// - In halt, stay idle until an enabled Port A pin falls.
// - Wake-up is enabled per Port A pin.
// - External interrupt input shares Port A bit 5.
// - Timer clock input shares Port A bit 4.
// - Divider output on Port A bit 3 only when direction is output.
// - PWM outputs on Port D bits 0 and 1 only when output.
// - Reset sets all data and direction registers to ones.
module gpp_top
	import gpp_pkg::*;
(
	input  wire logic                 REF_CLK,
	input  wire logic                 NRST,
	input  wire gpp_pkg::gpp_req_t    REQ,
	input  wire gpp_pkg::gpp_cfg_t    CFG,
	input  wire gpp_pkg::gpp_pm_t     POWER_MODE,
	input  wire logic                 IRQ_PIN_EN,
	input  wire logic                 TMR_EXT_SEL,
	input  wire logic                 FDIV_IN,
	input  wire logic                 PWM0_IN,
	input  wire logic                 PWM1_IN,
	input  wire logic [31:0]          PAD_IN,
	output logic      [31:0]          PAD_OUT,
	output logic      [31:0]          PAD_OE,
	output logic      [31:0]          PAD_PULL,
	output logic      [7:0]           RD_DATA,
	output logic                      RD_VALID,
	output logic                      WAKE,
	output logic                      EXT_IRQ_N,
	output logic                      TMR_CLK
);
	logic [31:0] pin_meta_ff;
	logic [31:0] pin_sync_ff;
	logic [7:0]  pa_prev_ff;
	logic [31:0] rd_all;
	logic [31:0] pad_out_w;
	logic [31:0] pad_oe_w;
	logic [31:0] dir_all;
	logic [31:0] alt_en;
	logic [31:0] alt_val;
	logic [3:0]  wr_data_sel;
	logic [3:0]  wr_dir_sel;
	logic [7:0]  rd_mux;
	logic [7:0]  pa_fall;
	logic        wake_hit;
	logic [31:0] pad_out_ff;
	logic [31:0] pad_oe_ff;
	logic [31:0] pad_pull_ff;
	logic [7:0]  rd_data_ff;
	logic        rd_valid_ff;
	logic        wake_ff;
	logic        irq_n_ff;
	logic        tmr_ff;

	// Two-flop pin synchroniser
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			pin_meta_ff <= 32'h0;
			pin_sync_ff <= 32'h0;
		end else begin
			pin_meta_ff <= PAD_IN;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_port
			assign wr_data_sel[g] = REQ.wr_en && !REQ.dir_sel && (REQ.port == ADDR_W'(g));
			assign wr_dir_sel[g]  = REQ.wr_en && REQ.dir_sel && (REQ.port == ADDR_W'(g));
			gpp_port #(.W(PORT_W)) u_port (
				.clk      (REF_CLK),
				.nrst     (NRST),
				.wr_data  (wr_data_sel[g]),
				.wr_dir   (wr_dir_sel[g]),
				.wdata    (REQ.wdata),
				.bit_mask (REQ.bit_mask),
				.alt_en   (alt_en[g*PORT_W +: PORT_W]),
				.alt_val  (alt_val[g*PORT_W +: PORT_W]),
				.pin_sync (pin_sync_ff[g*PORT_W +: PORT_W]),
				.rd_val   (rd_all[g*PORT_W +: PORT_W]),
				.pad_out  (pad_out_w[g*PORT_W +: PORT_W]),
				.pad_oe   (pad_oe_w[g*PORT_W +: PORT_W]),
				.dir_q    (dir_all[g*PORT_W +: PORT_W])
			);
		end
	endgenerate

	// PWM on port D, divider on port A
	always_comb begin
		alt_en  = 32'h0;
		alt_val = 32'h0;
		alt_en[BIT_FDIV]         = CFG.fdiv_en;
		alt_val[BIT_FDIV]        = FDIV_IN;
		alt_en[SEL_PORT_D*PORT_W + BIT_PWM0]  = CFG.pwm0_en;
		alt_val[SEL_PORT_D*PORT_W + BIT_PWM0] = PWM0_IN;
		alt_en[SEL_PORT_D*PORT_W + BIT_PWM1]  = CFG.pwm1_en;
		alt_val[SEL_PORT_D*PORT_W + BIT_PWM1] = PWM1_IN;
	end

	assign rd_mux = REQ.dir_sel ? dir_all[REQ.port*PORT_W +: PORT_W] : rd_all[REQ.port*PORT_W +: PORT_W];

	// falling edge on Port A, per-pin enable
	assign pa_fall  = pa_prev_ff & ~pin_sync_ff[7:0] & CFG.wake_en;
	assign wake_hit = (POWER_MODE == PM_HALT) && (pa_fall != 8'h0);

	// Registered outputs
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			pa_prev_ff  <= 8'h0;
			pad_out_ff  <= {NUM_PORTS{DATA_RST}};
			pad_oe_ff   <= ~{NUM_PORTS{DIR_RST}};
			pad_pull_ff <= 32'h0;
			rd_data_ff  <= 8'h0;
			rd_valid_ff <= 1'b0;
			wake_ff     <= 1'b0;
			irq_n_ff    <= 1'b1;
			tmr_ff      <= 1'b0;
		end else begin
			pa_prev_ff  <= pin_sync_ff[7:0];
			pad_out_ff  <= pad_out_w;
			pad_oe_ff   <= pad_oe_w;
			// pull-high only on inputs, static option
			pad_pull_ff <= CFG.pull_en & dir_all;
			rd_data_ff  <= rd_mux;
			rd_valid_ff <= REQ.rd_en;
			wake_ff     <= wake_hit;
			irq_n_ff    <= IRQ_PIN_EN ? pin_sync_ff[BIT_IRQ] : 1'b1;
			// timer clock only in external mode
			tmr_ff      <= TMR_EXT_SEL ? pin_sync_ff[BIT_TMR] : 1'b0;
		end
	end

	assign PAD_OUT   = pad_out_ff;
	assign PAD_OE    = pad_oe_ff;
	assign PAD_PULL  = pad_pull_ff;
	assign RD_DATA   = rd_data_ff;
	assign RD_VALID  = rd_valid_ff;
	assign WAKE      = wake_ff;
	assign EXT_IRQ_N = irq_n_ff;
	assign TMR_CLK   = tmr_ff;

	// Reset state of pins
	// all inputs after reset
	reset_inputs_a: assert property (@(posedge REF_CLK) !NRST |=> ##1 (PAD_OE == 32'h0))
		else $error("pins not inputs after reset");

	// halted and an enabled Port A pin fell
	sequence s_halt_fall;
		(POWER_MODE == PM_HALT) && ((CFG.wake_en & $past(pin_sync_ff[7:0]) & ~pin_sync_ff[7:0]) != 8'h0);
	endsequence

	wake_edge_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
		s_halt_fall |=> WAKE)
		else $error("wake missed");

	// no enabled fall in halt, no wake
	wake_gate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
		((POWER_MODE != PM_HALT) || ((CFG.wake_en & $past(pin_sync_ff[7:0]) & ~pin_sync_ff[7:0]) == 8'h0))
		|=> !WAKE)
		else $error("wake without enabled fall");

	// read of an output bit matches its driven latch
	read_latch_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
		(REQ.rd_en && !REQ.dir_sel && REQ.port == SEL_PORT_C && !dir_all[SEL_PORT_C*PORT_W])
		|=> RD_DATA[0] == PAD_OUT[SEL_PORT_C*PORT_W])
		else $error("output read not latch");

	fdiv_pin_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
		(CFG.fdiv_en && !dir_all[BIT_FDIV]) |=> PAD_OE[BIT_FDIV] && PAD_OUT[BIT_FDIV] == $past(FDIV_IN))
		else $error("divider not driven");

	// pull-high never on a driven pin
	pull_input_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
		(PAD_PULL & PAD_OE) == 32'h0)
		else $error("pull on output pin");

	irq_gate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
		!IRQ_PIN_EN |=> EXT_IRQ_N)
		else $error("irq leaked");

	tmr_gate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
		!TMR_EXT_SEL |=> !TMR_CLK)
		else $error("timer clock leaked");
endmodule : gpp_top

// ==== bench/gpp_pins.sv ====
// Board model that resolves each shared pin level
`timescale 1ns/1ps
module gpp_pins (
	input  wire logic [31:0] pad_out,
	input  wire logic [31:0] pad_oe,
	input  wire logic [31:0] pad_pull,
	input  wire logic [31:0] ext_val,
	input  wire logic [31:0] ext_en,
	output logic      [31:0] pad_in
);
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pad_pull | ~ext_val));
endmodule : gpp_pins

// ==== bench/gpp_top_bench.sv ====
// Self-checking bench for the shared-pin port block
`timescale 1ns/1ps
module gpp_top_bench;
	import gpp_pkg::*;
	logic clk = 0, nrst = 0, irq_en = 1, tsel = 1, fdiv = 0, pwm0 = 0, pwm1 = 0;
	gpp_req_t req = '0;
	gpp_cfg_t cfg;
	gpp_pm_t pm = PM_RUN;
	logic [31:0] ev = '1, ee = '1, pin, po, poe, ppu, r, seed = 32'h1AAF;
	logic [7:0] rdd, q[$];
	logic rdv, wake, irq_n, tclk;
	int failures = 0, n_tests = 0, nw = 0, w;
	always #50 clk = ~clk;
	gpp_top i_gpp_top (.REF_CLK(clk), .NRST(nrst), .REQ(req), .CFG(cfg), .POWER_MODE(pm), .IRQ_PIN_EN(irq_en),
		.TMR_EXT_SEL(tsel), .FDIV_IN(fdiv), .PWM0_IN(pwm0), .PWM1_IN(pwm1), .PAD_IN(pin), .PAD_OUT(po),
		.PAD_OE(poe), .PAD_PULL(ppu), .RD_DATA(rdd), .RD_VALID(rdv), .WAKE(wake), .EXT_IRQ_N(irq_n),
		.TMR_CLK(tclk));
	gpp_pins i_gpp_pins (.pad_out(po), .pad_oe(poe), .pad_pull(ppu), .ext_val(ev), .ext_en(ee), .pad_in(pin));
	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (e !== s) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// Write pulse, then wait until the pins show it
	task automatic wr(input logic s, input logic [1:0] p, input logic [7:0] v, input logic [7:0] m);
		@(negedge clk);
		req <= '{1'b1, 1'b0, s, p, v, m};
		@(negedge clk);
		req <= '0;
		repeat (2) @(negedge clk);
	endtask : wr
	// Read pulse with its expectation queued
	task automatic rd(input logic s, input logic [1:0] p, input logic [7:0] e);
		@(negedge clk);
		q.push_back(e);
		req <= '{1'b0, 1'b1, s, p, 8'h00, 8'h00};
		@(negedge clk);
		req <= '0;
	endtask : rd
	// Answer watcher and wake counter
	always @(negedge clk) begin
		if (rdv === 1'b1) chk("RD_DATA", q.pop_front(), rdd);
		if (wake === 1'b1) nw++;
	end
	initial begin
		#(3000 * 100);
		failures++;
		report_and_stop();
	end
	initial begin
		cfg = '{rnd(), 8'h04, 1'b1, 1'b1, 1'b0};
		repeat (10) @(negedge clk);
		nrst <= 1;
		@(negedge clk);
		chk("PAD_OE", 32'h0, poe);
		// Divider and PWM0 options pass their low inputs onto the idle pins
		chk("PAD_OUT", 32'hFEFFFFF7, po);
		for (int p = 0; p < 4; p++) rd(1'b1, p[1:0], DIR_RST);
		$display("done: reset");
		r = rnd();
		wr(1'b0, SEL_PORT_C, r[7:0], 8'hFF);
		wr(1'b1, SEL_PORT_C, 8'h00, 8'hFF);
		chk("PAD_OE C", 8'hFF, poe[23:16]);
		chk("PAD_OUT C", r[7:0], po[23:16]);
		rd(1'b0, SEL_PORT_C, r[7:0]);
		wr(1'b0, SEL_PORT_C, 8'h00, 8'h01);
		wr(1'b1, SEL_PORT_C, 8'hFF, 8'h80);
		chk("PAD_OE C", 8'h7F, poe[23:16]);
		repeat (3) @(negedge clk);
		rd(1'b0, SEL_PORT_C, {1'b1, r[6:1], 1'b0});
		$display("done: output latch");
		r = rnd();
		ev <= r;
		ee <= 32'h00FFFFFF;
		repeat (4) @(negedge clk);
		rd(1'b0, SEL_PORT_B, r[15:8]);
		chk("PAD_PULL", cfg.pull_en & 32'hFF80FFFF, ppu);
		rd(1'b0, SEL_PORT_D, cfg.pull_en[31:24] | ~r[31:24]);
		wr(1'b1, SEL_PORT_D, 8'hFC, 8'hFF);
		chk("PWM pins", 2'b10, po[25:24]);
		wr(1'b1, SEL_PORT_A, 8'hF7, 8'hFF);
		chk("FDIV low", 1'b0, po[3]);
		fdiv <= 1;
		repeat (2) @(negedge clk);
		chk("FDIV high", 1'b1, po[3]);
		$display("done: shared outputs");
		ev[7:0] <= 8'hEF;
		repeat (4) @(negedge clk);
		chk("EXT_IRQ_N", 1'b1, irq_n);
		chk("TMR_CLK", 1'b0, tclk);
		ev[5] <= 0;
		ev[4] <= 1;
		repeat (4) @(negedge clk);
		chk("EXT_IRQ_N", 1'b0, irq_n);
		chk("TMR_CLK", 1'b1, tclk);
		irq_en <= 0;
		tsel <= 0;
		repeat (3) @(negedge clk);
		chk("EXT_IRQ_N off", 1'b1, irq_n);
		chk("TMR_CLK off", 1'b0, tclk);
		$display("done: shared inputs");
		ev[7:0] <= 8'hFF;
		repeat (4) @(negedge clk);
		w = nw;
		ev[2] <= 0;
		repeat (5) @(negedge clk);
		chk("WAKE run", w, nw);
		ev[2] <= 1;
		pm <= PM_HALT;
		repeat (4) @(negedge clk);
		ev[1] <= 0;
		repeat (5) @(negedge clk);
		chk("WAKE masked", w, nw);
		ev[2] <= 0;
		repeat (5) @(negedge clk);
		chk("WAKE", w + 1, nw);
		$display("done: wake-up");
		chk("pending reads", 0, q.size());
		report_and_stop();
	end
endmodule : gpp_top_bench
